// >>> hdl/adc_ctl_pkg.sv
// shared constants for the converter control block and its host end
package adc_ctl_pkg;
  // -----------------------------------------------------------------
  // widths and lanes
  // -----------------------------------------------------------------
  localparam int RES_W       = 12;
  localparam int BUS_W       = 12;
  localparam int NIB_W       = 4;
  localparam logic [11:0] RESULT_RST = 12'h000;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_NS      = 8;
  localparam int CONV_NS     = 3000;
  localparam int REACQ_NS    = 1000;
  localparam int CONV_CYC    = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int REACQ_CYC   = (REACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 16;
  localparam int CONV_DIV    = 2;
endpackage

// >>> hdl/adc_bus_if.sv
// host bus between the converter and the microprocessor end
`timescale 1ns/1ps
interface adc_bus_if;
  logic        chip_select_n;
  logic        read_strobe_n;
  logic        high_byte_select;
  logic        busy_n;
  logic [11:0] data_out;
  logic [11:0] data_oe;

  modport dev (
    input  chip_select_n,
    input  read_strobe_n,
    input  high_byte_select,
    output busy_n,
    output data_out,
    output data_oe
  );
  modport host (
    output chip_select_n,
    output read_strobe_n,
    output high_byte_select,
    input  busy_n,
    input  data_out,
    input  data_oe
  );
endinterface

// >>> hdl/adc_ctl.sv
// converter end: read decode, conversion sequencer and output lanes
//
// What this block does
// - byte rom read starts conversion, returns old
// - host does two more reads for result
// - host waits conversion time before second read
// - high byte read: no start, msbs low
// - third read returns low byte, restarts
// - upper lines always carry four msbs
// - select and strobe act as memory strobes
// - even address starts, odd reads high byte
// - slow mode: busy holds host until done
// - high byte read after slow: no wait
// - host spaces rom starts by conversion time
// - host leaves 1us between conversions
// - conversion clock shares host clock
// - resync may delay start one conversion clock
// - sampling follows the synchronised strobe
// - start only on all low, no restart
// - busy low throughout conversion
// - high byte read drives lines 7 to 4 low
// - latch result on the same edge as busy release, right justified
`timescale 1ns/1ps
module adc_ctl #(
  parameter int CONV_CYCLES = adc_ctl_pkg::CONV_CYC,
  parameter int DIV         = adc_ctl_pkg::CONV_DIV
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // host bus
  adc_bus_if.dev                             bus,
  // converter core side
  input  wire logic [adc_ctl_pkg::RES_W-1:0] sample_value,
  output logic                               sample_take,
  output logic                               conv_active
);
  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic [2:0] cs_sy_ff;
  logic [2:0] rd_sy_ff;
  logic [2:0] hb_sy_ff;
  logic       cs_n_ff;
  logic       rd_n_ff;
  logic       hb_ff;

  // pins come from the host domain; a change counts when stages agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_sy_ff <= 3'h7;
      rd_sy_ff <= 3'h7;
      hb_sy_ff <= 3'h0;
    end else begin
      cs_sy_ff <= {cs_sy_ff[1:0], bus.chip_select_n};
      rd_sy_ff <= {rd_sy_ff[1:0], bus.read_strobe_n};
      hb_sy_ff <= {hb_sy_ff[1:0], bus.high_byte_select};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      hb_ff   <= 1'b0;
    end else begin
      if (cs_sy_ff[2] == cs_sy_ff[1])
        cs_n_ff <= cs_sy_ff[2];
      if (rd_sy_ff[2] == rd_sy_ff[1])
        rd_n_ff <= rd_sy_ff[2];
      if (hb_sy_ff[2] == hb_sy_ff[1])
        hb_ff <= hb_sy_ff[2];
    end
  end

  // -----------------------------------------------------------------
  // conversion clock enable
  // -----------------------------------------------------------------
  logic [7:0] div_ff;
  logic       conv_tick;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || div_ff == 8'(DIV - 1))
      div_ff <= 8'h00;
    else
      div_ff <= div_ff + 8'h01;
  end
  assign conv_tick = (div_ff == 8'h00);

  // -----------------------------------------------------------------
  // read decode
  // -----------------------------------------------------------------
  logic read_act;
  logic start_req;
  logic rd_act_d_ff;

  assign read_act  = !cs_n_ff && !rd_n_ff;
  assign start_req = read_act && !rd_act_d_ff && !hb_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      rd_act_d_ff <= 1'b0;
    else
      rd_act_d_ff <= read_act;
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;

  conv_state_t                   state_ff;
  logic [adc_ctl_pkg::CNT_W-1:0] cnt_ff;
  logic [adc_ctl_pkg::RES_W-1:0] result_ff;
  logic                          busy_n_ff;
  logic                          take_ff;

  // start waits for the next conversion clock tick, at most one period
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= '0;
      busy_n_ff     <= 1'b1;
      take_ff       <= 1'b0;
    end else begin
      take_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start_req) begin
            state_ff      <= ST_WAIT;
            busy_n_ff     <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (conv_tick) begin
            take_ff       <= 1'b1;
            cnt_ff        <= adc_ctl_pkg::CNT_W'(CONV_CYCLES - 1);
            state_ff      <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (cnt_ff == '0) begin
            busy_n_ff <= 1'b1;
            state_ff  <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - adc_ctl_pkg::CNT_W'(1);
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  logic [adc_ctl_pkg::RES_W-1:0] sampled_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sampled_ff <= adc_ctl_pkg::RESULT_RST;
      result_ff  <= adc_ctl_pkg::RESULT_RST;
    end else begin
      if (take_ff)
        sampled_ff <= sample_value;
      if (state_ff == ST_CONV && cnt_ff == '0)
        result_ff <= sampled_ff;
    end
  end

  // -----------------------------------------------------------------
  // output lanes
  // -----------------------------------------------------------------
  logic [11:0] dout_ff;
  logic [11:0] doe_ff;
  logic        take_o_ff;
  logic        active_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dout_ff   <= 12'h000;
      doe_ff    <= 12'h000;
      take_o_ff <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      take_o_ff <= take_ff;
      active_ff <= (state_ff == ST_CONV);
      doe_ff    <= read_act ? 12'hFFF : 12'h000;
      if (hb_ff) begin
        dout_ff <= {result_ff[11:8], 4'h0, result_ff[11:8]};
      end else begin
        dout_ff <= result_ff;
      end
    end
  end

  assign bus.busy_n   = busy_n_ff;
  assign bus.data_out = dout_ff;
  assign bus.data_oe  = doe_ff;
  assign sample_take  = take_o_ff;
  assign conv_active  = active_ff;
endmodule

// >>> hdl/adc_host.sv
// microprocessor end: issues memory-mapped reads to the converter
`timescale 1ns/1ps
module adc_host #(
  parameter int CONV_CYCLES  = adc_ctl_pkg::CONV_CYC,
  parameter int REACQ_CYCLES = adc_ctl_pkg::REACQ_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // user request: mode 0 slow memory, 1 rom byte sequence
  input  wire logic        req_valid,
  input  wire logic        req_rom,
  output logic             req_ready,
  // user answer
  output logic             rsp_valid,
  output logic [11:0]      rsp_data,
  // converter bus
  adc_bus_if.host          bus
);
  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_LOW  = 6'b000010,
    H_GAP  = 6'b000100,
    H_HIGH = 6'b001000,
    H_DONE = 6'b010000,
    H_LAST = 6'b100000
  } host_state_t;

  host_state_t  st_ff;
  logic [15:0]  cnt_ff;
  logic [2:0]   sb_ff;
  logic [11:0]  lo_ff;
  logic         rom_ff;
  logic         cs_n_ff;
  logic         rd_n_ff;
  logic         hb_ff;
  logic         rv_ff;
  logic [11:0]  rd_ff;

  // busy comes from another block's flops; synchronise as a pin
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      sb_ff <= 3'h7;
    else
      sb_ff <= {sb_ff[1:0], bus.busy_n};
  end

  // read held long enough for busy to appear before checking it
  localparam logic [15:0] HOLD = 16'h0010;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff   <= H_IDLE;
      cnt_ff  <= 16'h0000;
      lo_ff   <= 12'h000;
      rom_ff  <= 1'b0;
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      hb_ff   <= 1'b0;
      rv_ff   <= 1'b0;
      rd_ff   <= 12'h000;
    end else begin
      rv_ff <= 1'b0;
      if (cnt_ff != 16'h0000)
        cnt_ff <= cnt_ff - 16'h0001;
      case (st_ff)
        H_IDLE: begin
          if (req_valid && cnt_ff == 16'h0000) begin
            rom_ff  <= req_rom;
            hb_ff   <= 1'b0;
            cs_n_ff <= 1'b0;
            rd_n_ff <= 1'b0;
            cnt_ff  <= HOLD;
            st_ff   <= H_LOW;
          end
        end
        H_LOW: begin
          // slow mode waits on busy; rom takes old data
          if (cnt_ff == 16'h0000 && (rom_ff || (sb_ff[2] && sb_ff[1]))) begin
            lo_ff   <= bus.data_out;
            cs_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            cnt_ff  <= rom_ff ?
                       16'(CONV_CYCLES + REACQ_CYCLES + 32) : 16'h0004;
            st_ff   <= H_GAP;
          end
        end
        H_GAP: begin
          if (cnt_ff == 16'h0000) begin
            hb_ff   <= 1'b1;
            cs_n_ff <= 1'b0;
            rd_n_ff <= 1'b0;
            cnt_ff  <= HOLD;
            st_ff   <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (cnt_ff == 16'h0000) begin
            rd_ff   <= {bus.data_out[3:0], lo_ff[7:0]};
            cs_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            hb_ff   <= 1'b0;
            // rom mode needs a third read for the low byte
            cnt_ff  <= 16'h0004;
            st_ff   <= rom_ff ? H_LAST : H_DONE;
          end
        end
        H_LAST: begin
          // release gap first, so the converter sees a fresh read edge
          if (cs_n_ff && cnt_ff == 16'h0000) begin
            cs_n_ff <= 1'b0;
            rd_n_ff <= 1'b0;
            cnt_ff  <= HOLD;
          end else if (!cs_n_ff && cnt_ff == 16'h0000) begin
            // new low byte; this read also restarts a conversion
            rd_ff   <= {rd_ff[11:8], bus.data_out[7:0]};
            cs_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            st_ff   <= H_DONE;
          end
        end
        H_DONE: begin
          rv_ff  <= 1'b1;
          // same clock for both ends
          // rom mode left a conversion running: wait it out as well
          cnt_ff <= rom_ff ? 16'(CONV_CYCLES + REACQ_CYCLES + 32)
                           : 16'(REACQ_CYCLES + 32);
          st_ff  <= H_IDLE;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  // rom mode: the third read fetches the low byte and restarts
  assign req_ready            = (st_ff == H_IDLE) && (cnt_ff == 16'h0000);
  assign rsp_valid            = rv_ff;
  assign rsp_data             = rd_ff;
  assign bus.chip_select_n    = cs_n_ff;
  assign bus.read_strobe_n    = rd_n_ff;
  assign bus.high_byte_select = hb_ff;
endmodule

// >>> tb/adc_ctl_asserts.sv
// bus checker for the converter and host ends
`timescale 1ns/1ps
module adc_ctl_asserts #(
  parameter int CONV_CYCLES  = adc_ctl_pkg::CONV_CYC,
  parameter int REACQ_CYCLES = adc_ctl_pkg::REACQ_CYC
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // host bus
  input wire logic        chip_select_n,
  input wire logic        read_strobe_n,
  input wire logic        high_byte_select,
  input wire logic        busy_n,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe
);
  // ---------------------------------------------------------------
  // helper counters, all but busy_ff saturating so long idles never wrap
  // ---------------------------------------------------------------
  logic [7:0]  idle_ff, rd_ff, lo_ff, hb_ff;
  logic [15:0] busy_ff, gap_ff;
  logic        rd_on;
  assign rd_on = !chip_select_n && !read_strobe_n;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      idle_ff <= 8'hFF;
      lo_ff   <= 8'hFF;
      rd_ff   <= 8'h00;
      hb_ff   <= 8'h00;
      busy_ff <= 16'h0000;
      gap_ff  <= 16'hFFFF;
    end else begin
      idle_ff <= rd_on ? 8'h00 : idle_ff + {7'h00, idle_ff != 8'hFF};
      lo_ff   <= (rd_on && !high_byte_select) ? 8'h00 :
                 lo_ff + {7'h00, lo_ff != 8'hFF};
      rd_ff   <= rd_on ? rd_ff + {7'h00, rd_ff != 8'hFF} : 8'h00;
      hb_ff   <= (rd_on && high_byte_select) ?
                 hb_ff + {7'h00, hb_ff != 8'hFF} : 8'h00;
      busy_ff <= busy_n ? 16'h0000 : busy_ff + 16'h0001;
      gap_ff  <= busy_n ? gap_ff + {15'h0000, gap_ff != 16'hFFFF}
                        : 16'h0000;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  oe_idle_a: assert property (
    idle_ff >= 8'h08 |-> data_oe == 12'h000)
    else $error("outputs driven with no read");
  oe_whole_a: assert property (
    data_oe == 12'h000 || data_oe == 12'hFFF)
    else $error("partial output enable");
  oe_read_a: assert property (
    rd_ff == 8'h08 |-> data_oe == 12'hFFF)
    else $error("read held but outputs off");
  hb_lane_a: assert property (
    hb_ff >= 8'h08 |->
    data_out[7:4] == 4'h0 && data_out[3:0] == data_out[11:8])
    else $error("high byte lanes wrong");
  start_cause_a: assert property (
    $fell(busy_n) |-> lo_ff <= 8'h06)
    else $error("conversion without low byte read");
  busy_min_a: assert property (
    $fell(busy_n) |=> !busy_n [*8])
    else $error("busy released early");
  busy_len_a: assert property (
    $rose(busy_n) |->
    busy_ff >= CONV_CYCLES - 1 && busy_ff <= CONV_CYCLES + 4)
    else $error("busy length wrong");
  hb_nowait_a: assert property (
    busy_n && rd_on && high_byte_select |=> busy_n)
    else $error("high byte read started conversion");
  reacq_gap_a: assert property (
    $fell(busy_n) |-> gap_ff >= REACQ_CYCLES)
    else $error("start too soon after conversion");
  cover property ($fell(busy_n));
  cover property (hb_ff == 8'h08);
  cover property ($rose(busy_n));
endmodule

// >>> tb/sar_adc_host_read_control_test.sv
// self-checking bench joining the converter and host ends
`timescale 1ns/1ps
module sar_adc_host_read_control_test;
  localparam int CONV  = 20;
  localparam int REACQ = 10;
  logic        clk_sys      = 1'b0;
  logic        rst_n        = 1'b0;
  logic        req_valid    = 1'b0;
  logic        req_rom      = 1'b0;
  logic [11:0] sample_value = 12'h000;
  logic        got_first    = 1'b0;
  logic [7:0]  n_take       = 8'h00;
  logic        req_ready, rsp_valid, sample_take, conv_active;
  logic [11:0] rsp_data, first_rd, hb_rd;
  logic [11:0] prev = adc_ctl_pkg::RESULT_RST;
  int          n_fail = 0;
  int          tests_run = 0;
  adc_bus_if bus ();
  always #4 clk_sys = ~clk_sys;
  adc_ctl #(.CONV_CYCLES(CONV)) adc_ctl_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .bus(bus), .sample_value(sample_value),
    .sample_take(sample_take), .conv_active(conv_active));
  adc_host #(.CONV_CYCLES(CONV), .REACQ_CYCLES(REACQ)) adc_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req_rom(req_rom), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .bus(bus));
  adc_ctl_asserts #(.CONV_CYCLES(CONV), .REACQ_CYCLES(REACQ)) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .chip_select_n(bus.chip_select_n),
    .read_strobe_n(bus.read_strobe_n), .busy_n(bus.busy_n),
    .high_byte_select(bus.high_byte_select), .data_out(bus.data_out),
    .data_oe(bus.data_oe));
  // ---------------------------------------------------------------
  // bus capture: first read while busy, and high byte read
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (req_valid === 1'b1 && req_ready === 1'b1) begin
      got_first <= 1'b0;
      n_take    <= 8'h00;
    end else begin
      if (sample_take === 1'b1) begin
        n_take <= n_take + 8'h01;
      end
      if (bus.data_oe === 12'hFFF && bus.high_byte_select === 1'b0 &&
          bus.busy_n === 1'b0 && !got_first) begin
        first_rd  <= bus.data_out;
        got_first <= 1'b1;
      end
    end
    if (bus.data_oe === 12'hFFF && bus.high_byte_select === 1'b1) begin
      hb_rd <= bus.data_out;
    end
  end
  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one host transaction; both waits are bounded
  task automatic do_req(input logic rom, input logic [11:0] val);
    int n;
    n = 0;
    sample_value <= val;
    req_valid <= 1'b1;
    req_rom <= rom;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 5000);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      n_fail++;
      $display("ERROR %0t: no answer from host", $time);
    end
  endtask
  task automatic t_slow(input logic [11:0] val);
    do_req(1'b0, val);
    chk12(rsp_data, val);
    chk12(first_rd, prev);
    chk12(hb_rd, {val[11:8], 4'h0, val[11:8]});
    chk_cnt(n_take, 8'h01);
    chk_cnt({7'h00, conv_active}, 8'h00);
    prev = val;
  endtask
  task automatic t_rom(input logic [11:0] val);
    do_req(1'b1, val);
    chk12(first_rd, prev);
    chk12(rsp_data, val);
    chk12(hb_rd, {val[11:8], 4'h0, val[11:8]});
    chk_cnt(n_take, 8'h02);
    chk_cnt({7'h00, conv_active}, 8'h01);
    prev = val;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_slow(12'hA5C);
    t_rom(12'h3C7);
    t_rom(12'hFFF);
    t_slow(12'h000);
    t_rom(12'h801);
    wrap_up();
  end
  // every transaction is far below a thousand cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
